// ### dv/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic clk;
	logic rst_b;
	stm_pkg::stm_sfr_req_type sfr_req;
	stm_pkg::stm_events_type detect_raw;
	wire logic [7:0] sfr_rdata;
	wire logic [4:0] fine;
	wire logic [3:0] gain;
	wire logic [5:0] ma;
	wire logic uv_en;
	wire logic [2:0] thr;
	wire logic [13:0] thr_mv;
	wire logic ov_en;
	wire logic [3:0] bg;
	wire logic [3:0] ts;
	wire logic irq;
	int fail_count = 0;
	int total_checks = 0;
	typedef struct packed {
		logic [15:0] a;
		logic [7:0] w;
		logic [7:0] e;
	} stm_row_type;
	// Unmapped a00c must read zero; the last row clears the flags set by the row before it.
	stm_row_type rows [7] = '{'{16'ha00a, 8'hff, 8'h1f}, '{16'ha00b, 8'hff, 8'h0f},
		'{16'ha00d, 8'hff, 8'hf8}, '{16'ha00e, 8'ha5, 8'ha5}, '{16'ha00c, 8'h55, 8'h00},
		'{16'ha00f, 8'hff, 8'hf0}, '{16'ha00f, 8'h00, 8'h00}};

	stm_regs u_stm_regs (.clk(clk), .rst_b(rst_b), .sfr_req(sfr_req), .detect_raw(detect_raw),
		.sfr_rdata(sfr_rdata), .led_ref_fine_trim(fine), .led_current_gain_code(gain),
		.led_current_ma(ma), .low_supply_detect_enable(uv_en), .low_supply_threshold(thr),
		.low_supply_threshold_mv(thr_mv), .high_supply_detect_enable(ov_en),
		.bandgap_ref_trim(bg), .temp_sensor_ref_trim(ts), .supply_event_irq(irq));

	task automatic chk(input logic [13:0] got, input logic [13:0] exp);
		total_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask

	task automatic sfr_wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge clk);
		sfr_req <= '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
		@(posedge clk);
		sfr_req.wr <= 1'b0;
		@(negedge clk);
	endtask

	task automatic set_raw(input stm_pkg::stm_events_type v);
		@(posedge clk);
		detect_raw <= v;
	endtask

	task automatic sfr_rd(input logic [15:0] a, input logic [7:0] e);
		@(posedge clk);
		sfr_req <= '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
		@(posedge clk);
		sfr_req.rd <= 1'b0;
		@(negedge clk);
		chk({6'h00, sfr_rdata}, {6'h00, e});
	endtask

	task automatic give_verdict;
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	initial begin
		#20000;
		fail_count++;
		give_verdict();
	end

	initial begin
		rst_b = 1'b0;
		sfr_req = '0;
		detect_raw = '0;
		@(posedge clk);
		@(negedge clk);
		chk({8'h00, ma}, 14'h0000);
		chk(thr_mv, 14'h1388);
		chk({9'h000, uv_en, thr, ov_en}, 14'h0000);
		chk({13'h0000, irq}, 14'h0000);
		@(posedge clk);
		rst_b <= 1'b1;
		$display("test reset done");
		foreach (rows[i]) begin
			sfr_wr(rows[i].a, rows[i].w);
			sfr_rd(rows[i].a, rows[i].e);
		end
		chk({9'h000, uv_en, thr, ov_en}, 14'h001f);
		chk({6'h00, bg, ts}, 14'h00a5);
		chk({9'h000, fine}, 14'h001f);
		$display("test table done");
		for (int i = 0; i < 16; i++) begin
			sfr_wr(stm_pkg::STM_ADDR_GAIN, 8'(i));
			chk({8'h00, ma}, 14'(4 * i));
			sfr_wr(stm_pkg::STM_ADDR_DETECT, 8'((i % 8) << 4));
			chk(thr_mv, 14'(5000 + 500 * (i % 8)));
		end
		$display("test decode done");
		// Raw detectors high while both enables are off must leave no trace.
		sfr_wr(stm_pkg::STM_ADDR_DETECT, 8'h00);
		sfr_wr(stm_pkg::STM_ADDR_IRQ, 8'h80);
		set_raw('{high: 1'b1, low: 1'b1, thermal: 1'b0});
		sfr_rd(stm_pkg::STM_ADDR_IRQ, 8'h80);
		chk({13'h0000, irq}, 14'h0000);
		sfr_wr(stm_pkg::STM_ADDR_DETECT, 8'h88);
		sfr_rd(stm_pkg::STM_ADDR_IRQ, 8'he6);
		chk({13'h0000, irq}, 14'h0001);
		set_raw('0);
		sfr_rd(stm_pkg::STM_ADDR_IRQ, 8'he0);
		sfr_wr(stm_pkg::STM_ADDR_IRQ, 8'h80);
		sfr_rd(stm_pkg::STM_ADDR_IRQ, 8'h80);
		chk({13'h0000, irq}, 14'h0000);
		$display("test supply events done");
		sfr_wr(stm_pkg::STM_ADDR_IRQ, 8'h0f);
		set_raw('{high: 1'b0, low: 1'b0, thermal: 1'b1});
		set_raw('0);
		sfr_rd(stm_pkg::STM_ADDR_IRQ, 8'h10);
		chk({13'h0000, irq}, 14'h0000);
		// The event stands only at the edge that takes the clear, so the set must win.
		@(posedge clk);
		sfr_req <= '{addr: stm_pkg::STM_ADDR_IRQ, wr: 1'b1, rd: 1'b0, wdata: 8'h00};
		detect_raw <= '{high: 1'b0, low: 1'b0, thermal: 1'b1};
		@(posedge clk);
		sfr_req.wr <= 1'b0;
		detect_raw <= '0;
		sfr_rd(stm_pkg::STM_ADDR_IRQ, 8'h10);
		sfr_wr(stm_pkg::STM_ADDR_IRQ, 8'h00);
		sfr_rd(stm_pkg::STM_ADDR_IRQ, 8'h00);
		$display("test thermal done");
		sfr_wr(stm_pkg::STM_ADDR_GAIN, 8'h0f);
		sfr_rd(stm_pkg::STM_ADDR_GAIN, 8'h0f);
		@(posedge clk);
		rst_b <= 1'b0;
		@(negedge clk);
		chk({8'h00, ma}, 14'h0000);
		chk({6'h00, sfr_rdata}, 14'h0000);
		@(posedge clk);
		rst_b <= 1'b1;
		sfr_rd(stm_pkg::STM_ADDR_GAIN, 8'h00);
		chk(thr_mv, 14'h1388);
		$display("test second reset done");
		give_verdict();
	end
endmodule
`default_nettype wire

// ### src/stm_pkg.sv
`default_nettype none
package stm_pkg;
	localparam logic [15:0] STM_ADDR_FINE = 16'ha00a;
	localparam logic [15:0] STM_ADDR_GAIN = 16'ha00b;
	localparam logic [15:0] STM_ADDR_DETECT = 16'ha00d;
	localparam logic [15:0] STM_ADDR_BGTS = 16'ha00e;
	localparam logic [15:0] STM_ADDR_IRQ = 16'ha00f;
	localparam logic [7:0] STM_RST_VALUE = 8'h00;
	localparam int STM_UV_EN_BIT = 7;
	localparam int STM_UV_THR_LSB = 4;
	localparam int STM_OV_EN_BIT = 3;
	localparam int STM_BG_LSB = 4;
	localparam int STM_IRQ_EN_BIT = 7;
	localparam int STM_FLAG_LSB = 4;
	localparam int STM_RSVD_BIT = 3;
	localparam logic [13:0] STM_UV_BASE_MV = 14'h1388;
	localparam logic [13:0] STM_UV_STEP_MV = 14'h01f4;
	localparam logic [5:0] STM_GAIN_STEP_MA = 6'h04;

	typedef struct packed {
		logic [15:0] addr;
		logic wr;
		logic rd;
		logic [7:0] wdata;
	} stm_sfr_req_type;

	// Bit order matches the status fields: high, low, thermal.
	typedef struct packed {
		logic high;
		logic low;
		logic thermal;
	} stm_events_type;

	function automatic logic [13:0] stm_threshold_mv(input logic [2:0] code);
		stm_threshold_mv = STM_UV_BASE_MV + 14'(STM_UV_STEP_MV * {11'h000, code});
	endfunction

	function automatic logic [5:0] stm_gain_ma(input logic [3:0] code);
		stm_gain_ma = 6'(STM_GAIN_STEP_MA * {2'h0, code});
	endfunction
endpackage
`default_nettype wire

// ### src/stm_regs.sv
`timescale 1ns/1ps
`default_nettype none
module stm_regs (
	input wire logic clk,
	input wire logic rst_b,
	input wire stm_pkg::stm_sfr_req_type sfr_req,
	input wire stm_pkg::stm_events_type detect_raw,
	output wire logic [7:0] sfr_rdata,
	output wire logic [4:0] led_ref_fine_trim,
	output wire logic [3:0] led_current_gain_code,
	output wire logic [5:0] led_current_ma,
	output wire logic low_supply_detect_enable,
	output wire logic [2:0] low_supply_threshold,
	output wire logic [13:0] low_supply_threshold_mv,
	output wire logic high_supply_detect_enable,
	output wire logic [3:0] bandgap_ref_trim,
	output wire logic [3:0] temp_sensor_ref_trim,
	output wire logic supply_event_irq
);
	typedef struct packed {
		logic [4:0] fine;
		logic [3:0] gain;
		logic [5:0] gain_ma;
		logic uv_en;
		logic [2:0] uv_thr;
		logic [13:0] uv_mv;
		logic ov_en;
		logic [3:0] bg;
		logic [3:0] ts;
		logic irq_en;
		logic irq;
		logic [7:0] rdata;
	} stm_regs_state_type;

	stm_regs_state_type state_reg;
	stm_regs_state_type state_next;
	stm_pkg::stm_events_type live;
	logic [2:0] flags;
	logic irq_wr;

	// The analog comparators run all the time; the enables only mask what is reported.
	always_comb begin
		live.high = detect_raw.high & state_reg.ov_en;
		live.low = detect_raw.low & state_reg.uv_en;
		live.thermal = detect_raw.thermal;
	end

	assign irq_wr = sfr_req.wr && (sfr_req.addr == stm_pkg::STM_ADDR_IRQ);

	for (genvar i = 0; i < 3; i++) begin : g_flag
		stm_sticky_flag u_flag (
			.clk(clk),
			.rst_b(rst_b),
			.set(live[i]),
			.wr_en(irq_wr),
			.wr_val(sfr_req.wdata[stm_pkg::STM_FLAG_LSB + i]),
			.flag(flags[i])
		);
	end

	always_comb begin
		state_next = state_reg;
		if (sfr_req.wr) begin
			case (sfr_req.addr)
				stm_pkg::STM_ADDR_FINE: begin
					state_next.fine = sfr_req.wdata[4:0];
				end
				stm_pkg::STM_ADDR_GAIN: begin
					state_next.gain = sfr_req.wdata[3:0];
				end
				stm_pkg::STM_ADDR_DETECT: begin
					state_next.uv_en = sfr_req.wdata[stm_pkg::STM_UV_EN_BIT];
					state_next.uv_thr = sfr_req.wdata[stm_pkg::STM_UV_THR_LSB +: 3];
					state_next.ov_en = sfr_req.wdata[stm_pkg::STM_OV_EN_BIT];
				end
				stm_pkg::STM_ADDR_BGTS: begin
					state_next.bg = sfr_req.wdata[stm_pkg::STM_BG_LSB +: 4];
					state_next.ts = sfr_req.wdata[3:0];
				end
				stm_pkg::STM_ADDR_IRQ: begin
					state_next.irq_en = sfr_req.wdata[stm_pkg::STM_IRQ_EN_BIT];
				end
				default: begin
				end
			endcase
		end
		state_next.gain_ma = stm_pkg::stm_gain_ma(state_next.gain);
		state_next.uv_mv = stm_pkg::stm_threshold_mv(state_next.uv_thr);
		state_next.irq = state_reg.irq_en & (|flags);
		// Read data is captured at the strobe, so live bits show the detector state then.
		if (sfr_req.rd) begin
			case (sfr_req.addr)
				stm_pkg::STM_ADDR_FINE: begin
					state_next.rdata = {3'h0, state_reg.fine};
				end
				stm_pkg::STM_ADDR_GAIN: begin
					state_next.rdata = {4'h0, state_reg.gain};
				end
				stm_pkg::STM_ADDR_DETECT: begin
					state_next.rdata = {state_reg.uv_en, state_reg.uv_thr, state_reg.ov_en, 3'h0};
				end
				stm_pkg::STM_ADDR_BGTS: begin
					state_next.rdata = {state_reg.bg, state_reg.ts};
				end
				stm_pkg::STM_ADDR_IRQ: begin
					state_next.rdata = {state_reg.irq_en, flags, 1'h0, live};
				end
				default: begin
					state_next.rdata = 8'h00;
				end
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			state_reg <= '0;
			state_reg.uv_mv <= stm_pkg::STM_UV_BASE_MV;
		end else begin
			state_reg <= state_next;
		end
	end

	assign sfr_rdata = state_reg.rdata;
	assign led_ref_fine_trim = state_reg.fine;
	assign led_current_gain_code = state_reg.gain;
	assign led_current_ma = state_reg.gain_ma;
	assign low_supply_detect_enable = state_reg.uv_en;
	assign low_supply_threshold = state_reg.uv_thr;
	assign low_supply_threshold_mv = state_reg.uv_mv;
	assign high_supply_detect_enable = state_reg.ov_en;
	assign bandgap_ref_trim = state_reg.bg;
	assign temp_sensor_ref_trim = state_reg.ts;
	assign supply_event_irq = state_reg.irq;

	a_gain_write: assert property (@(posedge clk) disable iff (!rst_b)
		sfr_req.wr && sfr_req.addr == 16'ha00b |=> led_current_gain_code == $past(sfr_req.wdata[3:0])
		&& led_current_ma == 6'(6'h04 * {2'h0, $past(sfr_req.wdata[3:0])}))
		else $error("gain code or current not updated by write");

	a_detect_layout: assert property (@(posedge clk) disable iff (!rst_b)
		sfr_req.wr && sfr_req.addr == 16'ha00d |=>
		{low_supply_detect_enable, low_supply_threshold, high_supply_detect_enable}
		== $past(sfr_req.wdata[7:3]))
		else $error("detect trim fields misplaced");

	a_thr_decode: assert property (@(posedge clk) disable iff (!rst_b)
		low_supply_threshold_mv == 14'h1388 + 14'(14'h01f4 * {11'h000, low_supply_threshold}))
		else $error("low threshold decode wrong");

	a_low_gated: assert property (@(posedge clk) disable iff (!rst_b)
		sfr_req.rd && sfr_req.addr == 16'ha00f |=>
		sfr_rdata[1] == $past(detect_raw.low && low_supply_detect_enable))
		else $error("low live bit not gated by enable");

	a_high_gated: assert property (@(posedge clk) disable iff (!rst_b)
		sfr_req.rd && sfr_req.addr == 16'ha00f |=>
		sfr_rdata[2] == $past(detect_raw.high && high_supply_detect_enable))
		else $error("high live bit not gated by enable");

	a_flag_sets: assert property (@(posedge clk) disable iff (!rst_b)
		live.thermal |=> flags[0] ##1 (flags[0] || $past(irq_wr)))
		else $error("thermal flag not set by event");

	a_flag_holds: assert property (@(posedge clk) disable iff (!rst_b)
		flags[2] && !irq_wr |=> flags[2])
		else $error("high flag cleared without software");

	a_irq_enable: assert property (@(posedge clk) disable iff (!rst_b)
		supply_event_irq |-> $past(state_reg.irq_en) && $past(|flags))
		else $error("interrupt without enable and flag");

	a_thermal_live: assert property (@(posedge clk) disable iff (!rst_b)
		sfr_req.rd && sfr_req.addr == 16'ha00f |=> sfr_rdata[0] == $past(detect_raw.thermal))
		else $error("thermal live bit wrong");

	a_status_ro: assert property (@(posedge clk) disable iff (!rst_b)
		sfr_req.rd && sfr_req.addr == 16'ha00f |=> sfr_rdata[3] == 1'b0
		&& sfr_rdata[7] == $past(state_reg.irq_en))
		else $error("interrupt register read layout wrong");

	a_irq_raise: assert property (@(posedge clk) disable iff (!rst_b)
		state_reg.irq_en && (|flags) |=> supply_event_irq)
		else $error("interrupt not raised for enabled flag");

	a_irq_masked: assert property (@(posedge clk) disable iff (!rst_b)
		!state_reg.irq_en |=> !supply_event_irq)
		else $error("interrupt raised while disabled");

	a_low_flag_set: assert property (@(posedge clk) disable iff (!rst_b)
		live.low |=> flags[1])
		else $error("low flag not set by event");

	a_high_flag_set: assert property (@(posedge clk) disable iff (!rst_b)
		live.high |=> flags[2])
		else $error("high flag not set by event");

	// A clear of the thermal flag only takes effect in a cycle without a thermal detector event.
	a_flag_clear: assert property (@(posedge clk) disable iff (!rst_b)
		irq_wr && !sfr_req.wdata[4] && !live.thermal |=> !flags[0])
		else $error("thermal flag not cleared by software");

	a_flag_write: assert property (@(posedge clk) disable iff (!rst_b)
		irq_wr |=> flags == ($past(sfr_req.wdata[6:4]) | $past({live.high, live.low, live.thermal})))
		else $error("flag bits not written as stored value");

	a_enable_write: assert property (@(posedge clk) disable iff (!rst_b)
		irq_wr |=> state_reg.irq_en == $past(sfr_req.wdata[7]))
		else $error("interrupt enable not written");

	// Software may poll the last read value, so it must not drift between reads.
	a_rdata_holds: assert property (@(posedge clk) disable iff (!rst_b)
		!sfr_req.rd |=> $stable(sfr_rdata))
		else $error("read data changed without a read");

	a_unmapped_read: assert property (@(posedge clk) disable iff (!rst_b)
		sfr_req.rd && sfr_req.addr == 16'ha00c |=> sfr_rdata == 8'h00)
		else $error("unmapped read not zero");

	a_fine_write: assert property (@(posedge clk) disable iff (!rst_b)
		sfr_req.wr && sfr_req.addr == 16'ha00a |=>
		led_ref_fine_trim == $past(sfr_req.wdata[4:0]))
		else $error("fine trim not updated by write");

	a_bgts_write: assert property (@(posedge clk) disable iff (!rst_b)
		sfr_req.wr && sfr_req.addr == 16'ha00e |=>
		{bandgap_ref_trim, temp_sensor_ref_trim} == $past(sfr_req.wdata))
		else $error("bandgap or sensor trim not updated by write");
endmodule
`default_nettype wire

// ### src/stm_sticky_flag.sv
`timescale 1ns/1ps
`default_nettype none
module stm_sticky_flag (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic set,
	input wire logic wr_en,
	input wire logic wr_val,
	output wire logic flag
);
	typedef struct packed {
		logic flag;
	} stm_flag_state_type;

	stm_flag_state_type state_reg;
	stm_flag_state_type state_next;

	// A detector event in the cycle of a software clear keeps the flag set.
	always_comb begin
		state_next = state_reg;
		state_next.flag = (wr_en ? wr_val : state_reg.flag) | set;
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			state_reg <= '0;
		end else begin
			state_reg <= state_next;
		end
	end

	assign flag = state_reg.flag;
endmodule
`default_nettype wire
